// ==== bench/link_sink_model.sv ====
// link word sink standing in for the serializers of both links
module link_sink_model (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // words from the mapper
  input wire dl_map_pkg::link_word_t out_q,
  // counts of the last whole line, and a sticky sequence fault flag
  output logic [11:0] words_q,
  output logic [11:0] act_q,
  output logic seq_bad_q
);
  timeunit 1ns;
  timeprecision 1ps;
  import dl_map_pkg::*;
  // ======
  // line counters
  logic [11:0] cnt_q; // words in the running line
  logic [11:0] acnt_q; // active words in the running line
  logic [11:0] prev_q; // previous index
  logic live_q; // reset output has gone by
  logic run_q; // a real word was seen
  // a wrap to index 0 closes a line; the first edge still shows reset output, so skip it
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      {cnt_q, acnt_q, prev_q, words_q, act_q} <= '0;
      {live_q, run_q, seq_bad_q} <= 3'h0;
    end else if (!live_q) begin
      live_q <= 1'b1;
    end else begin
      run_q <= 1'b1;
      prev_q <= out_q.index;
      if (out_q.index == 12'h000) begin
        // the very first word opens a line but closes none
        if (run_q) begin
          words_q <= cnt_q;
          act_q <= acnt_q;
        end
        cnt_q <= 12'h001;
        acnt_q <= {11'h000, out_q.active};
      end else begin
        cnt_q <= cnt_q + 12'h001;
        acnt_q <= acnt_q + {11'h000, out_q.active};
      end
      // only a step of one or a wrap to zero is legal
      if (run_q && out_q.index != 12'h000 && out_q.index != prev_q + 12'h001) begin
        seq_bad_q <= 1'b1;
      end
      // active slots are the first 1920 of a line
      if (out_q.active != (out_q.index <= 12'h77F)) begin
        seq_bad_q <= 1'b1;
      end
    end
  end
endmodule

// ==== bench/tb_dl_rgb_mapper.sv ====
// self-checking bench of the dual-link rgb sample mapper
module tb_dl_rgb_mapper;
  timeunit 1ns;
  timeprecision 1ps;
  import dl_map_pkg::*;
  // ======
  // design ports
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  map_cfg_t cfg = '0;
  logic in_valid = 1'b0;
  pixel_pair_t in_pair = '0;
  logic in_ready_q;
  link_word_t out_q;
  logic underrun_q;
  logic [11:0] words_q;
  logic [11:0] act_q;
  logic seq_bad_q;
  // ======
  // bench state
  int err_total = 0;
  int tests_run = 0;
  int cyc = 0; // edge count, stamps taken pairs
  int seq = 0; // pair on offer
  logic mon_on = 1'b0; // word checks armed
  logic drv_on = 1'b0; // source running
  logic starve = 1'b0; // source pauses now and then
  logic acc = 1'b0; // pair taken at the last edge
  logic have = 1'b0; // current group carries a pair
  logic [11:0] exp_idx = 12'h000;
  logic [11:0] last = 12'h000;
  logic [19:0] w;
  pixel_pair_t cur;
  pixel_pair_t pq[$]; // pairs taken, oldest first
  int tq[$]; // edge of each take
  // aux values include the first and last excluded code at each end
  logic [9:0] aux_tab [8] = '{10'h000, 10'h003, 10'h3FC, 10'h3FF,
    10'h004, 10'h3FB, 10'h1A5, 10'h064};
  // 200 MHz word clock
  always #2.5 ref_clk = ~ref_clk;
  dl_rgb_mapper dut_u (.ref_clk(ref_clk), .srst(srst), .cfg(cfg), .in_valid(in_valid),
    .in_pair(in_pair), .in_ready_q(in_ready_q), .out_q(out_q), .underrun_q(underrun_q));
  link_sink_model sink_u (.ref_clk(ref_clk), .srst(srst), .out_q(out_q), .words_q(words_q),
    .act_q(act_q), .seq_bad_q(seq_bad_q));
  // ======
  // expected words
  function automatic pixel_t mk(input int k);
    pixel_t p;
    p.r = 12'(k * 37 + 5);
    p.g = 12'(k * 91 + 2);
    p.b = 12'(k * 53 + 9);
    p.aux = aux_tab[k % 8];
    return p;
  endfunction
  function automatic logic [9:0] up(input logic [11:0] s);
    return cfg.deep12 ? s[11:2] : s[9:0];
  endfunction
  function automatic logic [9:0] aux_w(input pixel_t p);
    logic [9:0] v;
    v = cfg.aux_nonpic ? {2'h0, p.aux[7:0]} : p.aux;
    if (!cfg.aux_present) v = 10'h064;
    else if (v < 10'h004) v = 10'h004;
    else if (v > 10'h3FB) v = 10'h3FB;
    return v;
  endfunction
  function automatic logic [9:0] pack_w(input pixel_t p);
    logic [9:0] v;
    v = {2'h0, p.g[1:0], p.b[1:0], p.r[1:0], 2'h0};
    v[8] = ^v[7:0];
    v[9] = ~v[8];
    return v;
  endfunction
  // slot order B G R G on the primary, B X R X on the secondary
  function automatic logic [19:0] exp_w(input pixel_pair_t q, input logic [1:0] s);
    logic [9:0] xe;
    logic [9:0] xo;
    xe = cfg.deep12 ? pack_w(q.even) : aux_w(q.even);
    xo = cfg.deep12 ? pack_w(q.odd) : aux_w(q.odd);
    case (s)
      2'h0: return {up(q.even.b), up(q.odd.b)};
      2'h1: return {up(q.even.g), xe};
      2'h2: return {up(q.even.r), up(q.odd.r)};
      default: return {up(q.odd.g), xo};
    endcase
  endfunction
  task automatic check(input logic [11:0] got, input logic [11:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    if (err_total == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ======
  // monitor: a pair taken at edge t can first fill the group shown from edge t+2
  always @(posedge ref_clk) begin
    cyc++;
    if (mon_on) begin
      if (out_q.index[1:0] == 2'h0) begin
        have = out_q.active && tq.size() > 0 && tq[0] <= cyc - 2;
        if (have) begin
          cur = pq.pop_front();
          void'(tq.pop_front());
        end
      end
      // blanking and starved groups carry 040h
      w = (have && out_q.active) ? exp_w(cur, out_q.index[1:0]) : {10'h040, 10'h040};
      check(12'(out_q.a), 12'(w[19:10]));
      check(12'(out_q.b), 12'(w[9:0]));
      check(out_q.index, exp_idx);
      exp_idx = (exp_idx == last) ? 12'h000 : exp_idx + 12'h001;
    end
    acc = !srst && in_valid && in_ready_q;
    if (acc) begin
      pq.push_back(in_pair);
      tq.push_back(cyc);
    end
  end
  // source: a request stands until taken, pauses only between pairs
  always @(negedge ref_clk) begin
    if (!drv_on) begin
      in_valid <= 1'b0;
      seq = 0;
    end else if (acc || !in_valid) begin
      if (acc) seq++;
      in_pair <= {mk(2 * seq + 1), mk(2 * seq)};
      in_valid <= !(starve && (cyc % 300) < 40);
    end
  end
  // one configuration: reset, then a whole line and its wrap
  task automatic run_case(input map_cfg_t c, input logic st, input logic [11:0] lst);
    mon_on = 1'b0;
    drv_on = 1'b0;
    srst = 1'b1;
    cfg = c;
    starve = st;
    last = lst;
    repeat (6) @(negedge ref_clk);
    check({10'h000, in_ready_q, underrun_q}, 12'h000);
    check(out_q.index, 12'h000);
    pq.delete();
    tq.delete();
    exp_idx = 12'h000;
    have = 1'b0;
    srst = 1'b0;
    drv_on = 1'b1;
    @(negedge ref_clk);
    mon_on = 1'b1;
    repeat (int'(lst) + 12) @(negedge ref_clk);
    check(words_q, lst + 12'h001);
    check(act_q, 12'h780);
    check({11'h000, seq_bad_q}, 12'h000);
    check({11'h000, underrun_q}, 12'h001);
  endtask
  // ======
  // every format and every line length
  initial begin
    run_case(map_cfg_t'{1'b0, RATE_24, 1'b1, 1'b0}, 1'b0, 12'hABD);
    run_case(map_cfg_t'{1'b0, RATE_25, 1'b0, 1'b0}, 1'b1, 12'hA4F);
    run_case(map_cfg_t'{1'b0, RATE_30, 1'b1, 1'b1}, 1'b0, 12'h897);
    run_case(map_cfg_t'{1'b1, RATE_30, 1'b0, 1'b0}, 1'b1, 12'h897);
    run_case(map_cfg_t'{1'b1, RATE_24, 1'b1, 1'b0}, 1'b0, 12'hABD);
    stop_test();
  end
  // watchdog well beyond the five lines
  initial begin
    repeat (20000) @(posedge ref_clk);
    err_total++;
    stop_test();
  end
endmodule

// ==== design/aux_word_filter.sv ====
// conditions the auxiliary component into a legal link word
`include "dl_map_regs.svh"

module aux_word_filter (
  // configuration
  input wire logic aux_present,
  input wire logic aux_nonpic,
  // sample in and word out
  input wire logic [9:0] aux_in,
  output logic [9:0] aux_out
);
  import dl_map_pkg::*;

  // ==================================================
  // width limit and clamp
  logic [9:0] raw; // after the width limit
  logic [9:0] clamped; // after the clamp

  // non-picture data keeps only eight significant bits
  assign raw = aux_nonpic ? {2'h0, aux_in[7:0]} : aux_in;
  // clamping rather than dropping keeps the word slot filled
  assign clamped = (raw < `AUX_MIN) ? `AUX_MIN :
                   (raw > `AUX_MAX) ? `AUX_MAX : raw;
  assign aux_out = aux_present ? clamped : `AUX_DEFAULT;
endmodule

// ==== design/dl_map_pkg.sv ====
// types shared by the dual-link rgb sample mapper
package dl_map_pkg;
  // picture rate groups, one-hot
  typedef enum logic [2:0] {
    RATE_24 = 3'h1,
    RATE_25 = 3'h2,
    RATE_30 = 3'h4
  } pic_rate_t;

  // static configuration
  typedef struct packed {
    logic deep12;
    pic_rate_t rate;
    logic aux_present;
    logic aux_nonpic;
  } map_cfg_t;

  // one source pixel, r, g and b in 12-bit fields, aux in a 10-bit field
  typedef struct packed {
    logic [11:0] r;
    logic [11:0] g;
    logic [11:0] b;
    logic [9:0] aux;
  } pixel_t;

  // pixel 2n and pixel 2n+1
  typedef struct packed {
    pixel_t odd;
    pixel_t even;
  } pixel_pair_t;

  // one word slot on both links
  typedef struct packed {
    logic active;
    logic [11:0] index;
    logic [9:0] a;
    logic [9:0] b;
  } link_word_t;
endpackage

// ==== design/dl_map_regs.svh ====
// constants of the dual-link rgb sample mapper
`ifndef DL_MAP_REGS_SVH
`define DL_MAP_REGS_SVH

// ==================================================
// line lengths, as last word index of a package
`define LAST_WORD_24 12'hABD
`define LAST_WORD_25 12'hA4F
`define LAST_WORD_30 12'h897
// last index of the 1920 active words
`define ACT_LAST_WORD 12'h77F

// ==================================================
// word values
`define AUX_DEFAULT 10'h064
`define AUX_MIN 10'h004
`define AUX_MAX 10'h3FB
`define AUX_NONPIC_MAX 10'h0FF
`define BLANK_WORD 10'h040

// ==================================================
// packed low-bit word fields
`define PK_INV_BIT 9
`define PK_PAR_BIT 8
`define PK_G_POS 6
`define PK_B_POS 4
`define PK_R_POS 2

`endif

// ==== design/dl_rgb_mapper.sv ====
// dual-link mapper of 4:4:4 rgb and rgb+aux pixels onto two word streams
`include "dl_map_regs.svh"

module dl_rgb_mapper (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // static configuration
  input wire dl_map_pkg::map_cfg_t cfg,
  // pixel pair source
  input wire logic in_valid,
  input wire dl_map_pkg::pixel_pair_t in_pair,
  output logic in_ready_q,
  // link word streams
  output dl_map_pkg::link_word_t out_q,
  // status
  output logic underrun_q
);
  import dl_map_pkg::*;

  // ==================================================
  // configuration capture
  map_cfg_t cfg_q; // held for the whole run

  // taken only while reset stands, so it cannot move in mid-line
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cfg_q <= cfg;
    end
  end

  // ==================================================
  // word counter
  logic [11:0] cnt_q; // word index inside the package
  logic [11:0] line_last; // last index for this rate
  logic last_word; // this is the final word of the line
  logic in_active; // index falls in the 1920 active words
  logic [1:0] phase; // slot within the four-word group

  // interlaced, progressive and segmented rates share these three totals
  assign line_last = (cfg_q.rate == RATE_24) ? `LAST_WORD_24 :
                     (cfg_q.rate == RATE_25) ? `LAST_WORD_25 :
                     `LAST_WORD_30;
  assign last_word = (cnt_q == line_last);
  assign in_active = (cnt_q <= `ACT_LAST_WORD);
  // the active span is a multiple of four, so the low index bits give the slot
  assign phase = cnt_q[1:0];

  // free running, so the serializers always get a word per clock
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cnt_q <= 12'h000;
    end else if (last_word) begin
      cnt_q <= 12'h000;
    end else begin
      cnt_q <= cnt_q + 12'h001;
    end
  end

  // ==================================================
  // input hold register
  pixel_pair_t hold_q; // one pair waiting
  logic hold_full_q; // hold register occupied
  logic hold_full_d;
  logic accept; // a pair is taken from the source
  logic take; // a group begins and needs a pair
  logic take_ok; // the pair is there
  logic starved; // the pair is missing

  assign accept = in_valid && in_ready_q;
  assign take = in_active && (phase == 2'h0);
  assign take_ok = take && hold_full_q;
  assign starved = take && !hold_full_q;
  // accept only happens while empty and take_ok only while full
  assign hold_full_d = accept || (hold_full_q && !take_ok);

  // data register: loaded on accept only
  always_ff @(posedge ref_clk) begin
    if (accept) begin
      hold_q <= in_pair;
    end
  end

  // occupancy and ready; ready stays low during reset
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      hold_full_q <= 1'b0;
      in_ready_q <= 1'b0;
    end else begin
      hold_full_q <= hold_full_d;
      in_ready_q <= !hold_full_d;
    end
  end

  // ==================================================
  // working pair
  pixel_pair_t work_q; // pair being sent in this group
  logic group_ok_q; // this group has real pixels
  pixel_pair_t cur; // pair used by the current word
  logic word_ok; // current word carries pixel data

  // in the first slot the pair comes straight from the hold register
  assign cur = take ? hold_q : work_q;
  assign word_ok = take ? hold_full_q : group_ok_q;

  always_ff @(posedge ref_clk) begin
    if (take_ok) begin
      work_q <= hold_q;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      group_ok_q <= 1'b0;
    end else if (take) begin
      group_ok_q <= hold_full_q;
    end
  end

  // sticky; a missing pair is a source fault, so only reset clears it
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      underrun_q <= 1'b0;
    end else if (starved) begin
      underrun_q <= 1'b1;
    end
  end

  // ==================================================
  // component selection
  logic [9:0] b_even; // blue 2n, upper ten or plain ten
  logic [9:0] g_even;
  logic [9:0] r_even;
  logic [9:0] b_odd;
  logic [9:0] g_odd;
  logic [9:0] r_odd;

  // 12-bit mode drops the two low bits here; they travel in the packed word
  assign b_even = cfg_q.deep12 ? cur.even.b[11:2] : cur.even.b[9:0];
  assign g_even = cfg_q.deep12 ? cur.even.g[11:2] : cur.even.g[9:0];
  assign r_even = cfg_q.deep12 ? cur.even.r[11:2] : cur.even.r[9:0];
  assign b_odd = cfg_q.deep12 ? cur.odd.b[11:2] : cur.odd.b[9:0];
  assign g_odd = cfg_q.deep12 ? cur.odd.g[11:2] : cur.odd.g[9:0];
  assign r_odd = cfg_q.deep12 ? cur.odd.r[11:2] : cur.odd.r[9:0];

  // ==================================================
  // packed low bits and auxiliary words
  logic [9:0] pk_even; // low bits of pixel 2n
  logic [9:0] pk_odd; // low bits of pixel 2n+1
  logic [9:0] aux_even; // auxiliary word 2n
  logic [9:0] aux_odd; // auxiliary word 2n+1

  // one packer per pixel, so slots 1 and 3 each find their word ready
  low_bit_packer u_pack_even (
    .pix(cur.even),
    .word(pk_even)
  );

  low_bit_packer u_pack_odd (
    .pix(cur.odd),
    .word(pk_odd)
  );

  aux_word_filter u_aux_even (
    .aux_present(cfg_q.aux_present),
    .aux_nonpic(cfg_q.aux_nonpic),
    .aux_in(cur.even.aux),
    .aux_out(aux_even)
  );

  aux_word_filter u_aux_odd (
    .aux_present(cfg_q.aux_present),
    .aux_nonpic(cfg_q.aux_nonpic),
    .aux_in(cur.odd.aux),
    .aux_out(aux_odd)
  );

  // ==================================================
  // word multiplex
  logic [9:0] a_sel; // primary link word for this slot
  logic [9:0] b_sel; // secondary link word for this slot
  logic [9:0] b_slot1; // aux or packed word, slot 1
  logic [9:0] b_slot3; // aux or packed word, slot 3
  logic [9:0] a_next;
  logic [9:0] b_next;

  // primary: blue, green and red of the even pixel, then green of the odd pixel
  assign a_sel = (phase == 2'h0) ? b_even :
                 (phase == 2'h1) ? g_even :
                 (phase == 2'h2) ? r_even :
                 g_odd;
  // 12-bit carries packed low bits where 10-bit carries aux
  assign b_slot1 = cfg_q.deep12 ? pk_even : aux_even;
  assign b_slot3 = cfg_q.deep12 ? pk_odd : aux_odd;
  // secondary: odd blue and red around the aux or packed words
  assign b_sel = (phase == 2'h0) ? b_odd :
                 (phase == 2'h1) ? b_slot1 :
                 (phase == 2'h2) ? r_odd :
                 b_slot3;
  // blanking and missing pixels send the blanking level, not stale data
  assign a_next = (in_active && word_ok) ? a_sel : `BLANK_WORD;
  assign b_next = (in_active && word_ok) ? b_sel : `BLANK_WORD;

  // ==================================================
  // output register
  logic out_ok_q; // output word carries pixel data, helper for checks

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      out_q <= '0;
      out_ok_q <= 1'b0;
    end else begin
      out_q.active <= in_active;
      out_q.index <= cnt_q;
      out_q.a <= a_next;
      out_q.b <= b_next;
      out_ok_q <= in_active && word_ok;
    end
  end

  // ==================================================
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  logic pk_slot; // output holds a packed word on the secondary link
  logic aux_slot; // output holds an aux word on the secondary link
  assign pk_slot = out_ok_q && cfg_q.deep12 && out_q.index[0];
  assign aux_slot = out_ok_q && !cfg_q.deep12 && out_q.index[0];

  chk_count_wrap: assert property (last_word |=> cnt_q == 12'h000 ##1 cnt_q == 12'h001)
    else $error("word counter did not wrap to zero");
  // line totals are watched on the output index, not on the counter's own limit
  chk_rate_total: assert property ((cfg_q.rate == RATE_24 && out_q.index == 12'hABC) |=>
    out_q.index == 12'hABD)
    else $error("24 Hz line is not 2750 words");
  chk_short_wrap: assert property ((cfg_q.rate == RATE_25 && out_q.index == 12'hA4F) ||
    (cfg_q.rate == RATE_30 && out_q.index == 12'h897) |=> out_q.index == 12'h000)
    else $error("short line did not wrap at its total");
  chk_total_bound: assert property (out_q.index <= line_last)
    else $error("word index beyond package length");
  chk_active_span: assert property (out_q.active |-> out_q.index <= 12'h77F)
    else $error("active word outside the first 1920");
  chk_primary_blue: assert property (take_ok && !cfg_q.deep12 |=>
    out_q.a == $past(hold_q.even.b[9:0]))
    else $error("primary slot 0 is not blue 2n");
  chk_deep_order: assert property (take_ok && cfg_q.deep12 |=>
    out_q.a == $past(hold_q.even.b[11:2]) ##1 out_q.a == $past(work_q.even.g[11:2]))
    else $error("12-bit primary order wrong");
  chk_packed_lows: assert property (take_ok && cfg_q.deep12 |=> ##1
    out_q.b[7:2] == {$past(work_q.even.g[1:0]), $past(work_q.even.b[1:0]),
    $past(work_q.even.r[1:0])})
    else $error("packed low bits misplaced");
  // later slots of a group look back at the pair that its start took
  chk_second_blue: assert property (take_ok && !cfg_q.deep12 |=>
    out_q.b == $past(hold_q.odd.b[9:0]))
    else $error("secondary slot 0 is not blue 2n+1");
  chk_green_odd: assert property (take_ok && !cfg_q.deep12 |=> ##3
    out_q.a == $past(work_q.odd.g[9:0]))
    else $error("primary slot 3 is not green 2n+1");
  chk_deep_second: assert property (take_ok && cfg_q.deep12 |=>
    out_q.b == $past(hold_q.odd.b[11:2]))
    else $error("12-bit secondary slot 0 is not upper blue 2n+1");
  chk_deep_red: assert property (take_ok && cfg_q.deep12 |=> ##2
    out_q.a == $past(work_q.even.r[11:2]))
    else $error("12-bit primary slot 2 is not upper red 2n");
  // a missing pair must show as blanking, never as the previous pair again
  chk_starve_blank: assert property (starved |=>
    out_q.a == 10'h040 && out_q.b == 10'h040)
    else $error("starved group not sent as blanking");
  chk_pack_parity: assert property (pk_slot |-> ^out_q.b[8:0] == 1'b0)
    else $error("packed word parity not even");
  chk_pack_invert: assert property (pk_slot |-> out_q.b[9] != out_q.b[8])
    else $error("packed bit 9 not inverse of bit 8");
  chk_pack_reserved: assert property (pk_slot |-> out_q.b[1:0] == 2'h0)
    else $error("packed reserved bits not zero");
  chk_aux_default: assert property (aux_slot && !cfg_q.aux_present |-> out_q.b == 10'h064)
    else $error("absent aux not sent as 064h");
  chk_aux_legal: assert property (aux_slot |-> out_q.b >= 10'h004 && out_q.b <= 10'h3FB)
    else $error("excluded aux code sent");
  chk_aux_narrow: assert property (aux_slot && cfg_q.aux_nonpic |-> out_q.b <= 10'h0FF)
    else $error("non-picture aux wider than 8 bits");

  cov_deep_group: cover property (take_ok && cfg_q.deep12);
  cov_aux_group: cover property (take_ok && cfg_q.aux_present && !cfg_q.deep12);
  cov_starved: cover property (starved);
  cov_line_wrap: cover property (last_word ##1 take_ok);
endmodule

// ==== design/low_bit_packer.sv ====
// packs the two low bits of r, g and b into one parity-protected word
`include "dl_map_regs.svh"

module low_bit_packer (
  // pixel in
  input wire dl_map_pkg::pixel_t pix,
  // packed word out
  output logic [9:0] word
);
  import dl_map_pkg::*;

  // ==================================================
  // field placement
  logic [7:0] low_byte; // bits 7..0 of the word
  logic even_parity_bit; // makes bits 8..0 even

  assign low_byte = ({6'h00, pix.g[1:0]} << `PK_G_POS)
                  | ({6'h00, pix.b[1:0]} << `PK_B_POS)
                  | ({6'h00, pix.r[1:0]} << `PK_R_POS);
  // reserved bits 1 and 0 stay zero since nothing is shifted into them
  assign even_parity_bit = ^low_byte;
  assign word = {~even_parity_bit, even_parity_bit, low_byte};
endmodule
